/* File: sync_serial_partner.sv */
// external clocked-serial master that drives the port's link pins
`timescale 1ns/1ps
module sync_serial_partner (
    output logic link_clk,
    output logic link_data,
    input wire logic line_data
);
    // ------------------------------------------------------------
    // frame driver
    // ------------------------------------------------------------
    initial begin
        link_clk = 1'b1;
        link_data = 1'b1;
    end
    // clock stands high between frames; one cycle per data bit
    task automatic xfer(input logic [8:0] tx, input int n,
        output logic [8:0] rx);
        rx = 9'h000;
        for (int i = 0; i < n; i++) begin
            link_clk = 1'b0;
            link_data = tx[i];
            #62.5 rx[i] = line_data;
            link_clk = 1'b1;
            #62.5;
        end
        // hold time over: show the inverse rather than stale data
        link_data = ~tx[n - 1];
        #62.5;
    endtask : xfer
endmodule : sync_serial_partner

/* File: sync_serial_pkg.sv */
// package: register map, field positions and shared types of the sync serial port
package sync_serial_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_GLOBAL_INT_CONTROL = 5'h00;
    localparam logic [4:0] OFS_PERIPH_INT_ENABLE = 5'h04;
    localparam logic [4:0] OFS_PERIPH_INT_FLAGS = 5'h08;
    localparam logic [4:0] OFS_RX_DATA = 5'h0C;
    localparam logic [4:0] OFS_RX_STATUS_CONTROL = 5'h10;
    localparam logic [4:0] OFS_TX_STATUS_CONTROL = 5'h14;
    localparam logic [4:0] OFS_TX_DATA = 5'h18;
    localparam logic [4:0] OFS_BAUD_DIVISOR = 5'h1C;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int GIC_GLOBAL_INT_ENABLE = 7;
    localparam int GIC_PERIPHERAL_INT_ENABLE = 6;
    localparam int PIE_RX = 5;
    localparam int PIE_TX = 4;
    localparam int RCS_SERIAL_PORT_ENABLE = 7;
    localparam int RCS_RX_NINE_BIT = 6;
    localparam int RCS_SINGLE_RECEIVE = 5;
    localparam int RCS_CONTINUOUS_RECEIVE = 4;
    localparam int RCS_ADDRESS_DETECT = 3;
    localparam int RCS_FRAMING_ERROR = 2;
    localparam int RCS_OVERRUN_ERROR = 1;
    localparam int RCS_RX_NINTH_BIT = 0;
    localparam int TXS_CLOCK_SOURCE_MASTER = 7;
    localparam int TXS_TX_NINE_BIT = 6;
    localparam int TXS_TRANSMIT_ENABLE = 5;
    localparam int TXS_CLOCKED_MODE = 4;
    localparam int TXS_BAUD_HIGH_SPEED = 2;
    localparam int TXS_TX_SHIFT_EMPTY = 1;
    localparam int TXS_TX_NINTH_BIT = 0;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] RESET_TX_STATUS = 8'h02;
    localparam logic [1:0] RX_FIFO_DEPTH = 2'h2;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one received character: ninth bit, framing error, low byte
    typedef struct packed {
        logic ninth;
        logic framing;
        logic [7:0] data;
    } rx_char_t;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_MASTER,
        MODE_SLAVE,
        MODE_ASYNC
    } port_mode_t;

endpackage : sync_serial_pkg

/* File: sync_serial_port.sv */
// clocked-mode serial port with master clocking and slave operation
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module sync_serial_port
    import sync_serial_pkg::*;
#(
    parameter int DIV_WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_active,
    input wire logic serial_clock_in,
    output logic serial_clock_out,
    output logic serial_clock_oe_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_n,
    output logic wake_request,
    output logic vector_request
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] global_int_control;
    logic [7:0] peripheral_int_enable_one;
    logic [7:0] rcs;
    logic [7:0] txs;
    logic [DIV_WIDTH-1:0] baud_divisor;
    logic [7:0] tx_holding_register;
    logic tx_holding_ninth;
    logic tx_holding_full;
    rx_char_t rx_fifo [2];
    logic rx_rd_ptr;
    logic [1:0] rx_count;
    logic overrun_error_flag;
    logic [8:0] tx_shift_register;
    logic [3:0] tx_bits_left;
    logic [8:0] rx_shift_register;
    logic [3:0] rx_bits_got;
    logic [DIV_WIDTH:0] div_count;
    logic ck_sync1, ck_sync2, ck_prev;
    logic dt_sync1, dt_sync2;

    wire serial_port_enable = rcs[RCS_SERIAL_PORT_ENABLE];
    wire single_receive_enable = rcs[RCS_SINGLE_RECEIVE];
    wire continuous_receive_enable = rcs[RCS_CONTINUOUS_RECEIVE];
    wire transmit_enable = txs[TXS_TRANSMIT_ENABLE];

    function automatic port_mode_t decode_mode(input logic [7:0] t,
                                               input logic en);
        if (!en)
            return MODE_OFF;
        if (!t[TXS_CLOCKED_MODE])
            return MODE_ASYNC;
        return t[TXS_CLOCK_SOURCE_MASTER] ? MODE_MASTER : MODE_SLAVE;
    endfunction : decode_mode

    port_mode_t mode;
    assign mode = decode_mode(txs, serial_port_enable);
    wire slave = (mode == MODE_SLAVE);
    wire master = (mode == MODE_MASTER);
    wire rx_dir = single_receive_enable | continuous_receive_enable;
    // slave receive follows continuous enable only; single is ignored
    wire rx_on = slave ? continuous_receive_enable
                       : rx_dir;
    // master clocks stop in sleep; slave keeps going on the pin clock
    wire run = master ? !sleep_active : slave;

    // ------------------------------------------------------------
    // link sampling and shift edges
    // ------------------------------------------------------------
    // pin clock is sampled; sleep does not stop this sampling, only the master clock
    always_ff @(posedge aclk) begin
        ck_sync1 <= serial_clock_in;
        ck_sync2 <= ck_sync1;
        ck_prev <= ck_sync2;
        dt_sync1 <= serial_data_in;
        dt_sync2 <= dt_sync1;
    end

    logic int_ck;
    wire busy = (tx_bits_left != 4'h0) || (rx_bits_got != 4'h0)
                || (master && rx_on && !overrun_error_flag);
    wire div_tick = (div_count[DIV_WIDTH-1:0] == baud_divisor);
    always_ff @(posedge aclk) begin
        if (!aresetn || !master || !busy || !run) begin
            div_count <= '0;
            int_ck <= 1'b0;
        end else if (div_tick) begin
            div_count <= '0;
            int_ck <= !int_ck;
        end else begin
            div_count <= div_count + 1'b1;
        end
    end

    // clock idles high: leading edge falls, trailing edge rises
    wire lead = slave ? (!ck_sync2 && ck_prev)
                      : (master && run && div_tick && !int_ck);
    wire trail = slave ? (ck_sync2 && !ck_prev)
                       : (master && run && div_tick && int_ck);

    // ------------------------------------------------------------
    // transmit path
    // ------------------------------------------------------------
    wire tx_mode = !rx_dir && transmit_enable && (master || slave);
    wire [3:0] char_bits = txs[TXS_TX_NINE_BIT] ? BITS_NINE : BITS_EIGHT;
    wire [3:0] rx_bits = rcs[RCS_RX_NINE_BIT] ? BITS_NINE : BITS_EIGHT;
    wire tsr_empty = (tx_bits_left == 4'h0);
    logic tx_write;
    logic tx_bit_out;

    always_ff @(posedge aclk) begin
        if (!aresetn || !serial_port_enable) begin
            tx_shift_register <= '0;
            tx_bits_left <= 4'h0;
            tx_holding_full <= 1'b0;
            tx_holding_register <= RESET_BYTE;
            tx_holding_ninth <= 1'b0;
            tx_bit_out <= 1'b1;
        end else begin
            if (tx_write) begin
                tx_holding_register <= w_data[7:0];
                tx_holding_ninth <= txs[TXS_TX_NINTH_BIT];
                tx_holding_full <= 1'b1;
            end
            if (tsr_empty && tx_holding_full && tx_mode
                && !tx_write) begin
                tx_shift_register <= {tx_holding_ninth,
                                      tx_holding_register};
                tx_bits_left <= char_bits;
                tx_holding_full <= 1'b0;
            end else if (!tsr_empty && lead && tx_mode) begin
                tx_bit_out <= tx_shift_register[0];
                tx_shift_register <= {1'b0, tx_shift_register[8:1]};
            end else if (!tsr_empty && trail && tx_mode) begin
                tx_bits_left <= tx_bits_left - 4'h1;
            end
        end
    end
    wire tx_buffer_empty_flag = !tx_holding_full;

    // ------------------------------------------------------------
    // receive path
    // ------------------------------------------------------------
    logic rx_read;
    wire rx_done = rx_on && trail && !overrun_error_flag
                   && (rx_bits_got == rx_bits - 4'h1);
    wire rx_push = rx_done && (rx_count < RX_FIFO_DEPTH);
    wire rx_pop = rx_read && (rx_count != 2'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn || !serial_port_enable || !rx_on) begin
            rx_shift_register <= '0;
            rx_bits_got <= 4'h0;
        end else if (trail && !overrun_error_flag) begin
            rx_shift_register <= {dt_sync2, rx_shift_register[8:1]};
            rx_bits_got <= rx_done ? 4'h0 : rx_bits_got + 4'h1;
        end
    end

    wire [8:0] rx_word = rcs[RCS_RX_NINE_BIT]
        ? {dt_sync2, rx_shift_register[8:1]}
        : {1'b0, dt_sync2, rx_shift_register[8:2]};

    always_ff @(posedge aclk) begin
        if (!aresetn || !serial_port_enable) begin
            rx_count <= 2'h0;
            rx_rd_ptr <= 1'b0;
            rx_fifo[0] <= '0;
            rx_fifo[1] <= '0;
        end else begin
            if (rx_push) begin
                rx_fifo[rx_rd_ptr ^ rx_count[0]] <=
                    '{ninth: rx_word[8], framing: 1'b0,
                      data: rx_word[7:0]};
            end
            if (rx_pop)
                rx_rd_ptr <= !rx_rd_ptr;
            rx_count <= rx_count + {1'b0, rx_push} - {1'b0, rx_pop};
        end
    end

    // single-shot ends after one character; overrun blocks intake
    always_ff @(posedge aclk) begin
        if (!aresetn || !serial_port_enable || !continuous_receive_enable
            && !single_receive_enable) begin
            overrun_error_flag <= 1'b0;
        end else if (rx_done && rx_count == RX_FIFO_DEPTH) begin
            overrun_error_flag <= 1'b1;
        end else if (!continuous_receive_enable && rx_pop) begin
            overrun_error_flag <= 1'b0;
        end
    end

    rx_char_t rx_top;
    assign rx_top = rx_fifo[rx_rd_ptr];
    wire rx_char_flag = (rx_count != 2'h0);

    // ------------------------------------------------------------
    // pins and wake
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_clock_out <= 1'b1;
            serial_clock_oe_n <= 1'b1;
            serial_data_out <= 1'b1;
            serial_data_oe_n <= 1'b1;
            wake_request <= 1'b0;
            vector_request <= 1'b0;
        end else begin
            serial_clock_out <= !int_ck;
            serial_clock_oe_n <= !master;
            serial_data_out <= tx_bit_out;
            serial_data_oe_n <= !tx_mode;
            wake_request <= global_int_control[GIC_PERIPHERAL_INT_ENABLE]
                && (peripheral_int_enable_one[PIE_TX]
                    && tx_buffer_empty_flag
                    || peripheral_int_enable_one[PIE_RX]
                    && rx_char_flag);
            vector_request <= global_int_control[GIC_GLOBAL_INT_ENABLE]
                && global_int_control[GIC_PERIPHERAL_INT_ENABLE]
                && (peripheral_int_enable_one[PIE_TX]
                    && tx_buffer_empty_flag
                    || peripheral_int_enable_one[PIE_RX]
                    && rx_char_flag);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic [4:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_held, w_held;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    assign tx_write = do_write && (aw_addr == OFS_TX_DATA) && w_strb[0];
    wire single_done = rx_done && !slave && !continuous_receive_enable;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            s_axi_wready <= !w_held && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr > OFS_BAUD_DIVISOR)
                    ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_int_control <= RESET_BYTE;
            peripheral_int_enable_one <= RESET_BYTE;
            rcs <= RESET_BYTE;
            txs <= RESET_BYTE;
            baud_divisor <= '0;
        end else begin
            if (do_write && w_strb[0]) begin
                unique case (aw_addr)
                    OFS_GLOBAL_INT_CONTROL: global_int_control <= w_data[7:0];
                    OFS_PERIPH_INT_ENABLE:
                        peripheral_int_enable_one <= w_data[7:0];
                    OFS_RX_STATUS_CONTROL: rcs <= w_data[7:0];
                    OFS_TX_STATUS_CONTROL: txs <= w_data[7:0];
                    OFS_BAUD_DIVISOR: baud_divisor <= w_data[DIV_WIDTH-1:0];
                    default: ;
                endcase
            end
            if (single_done)
                rcs[RCS_SINGLE_RECEIVE] <= 1'b0;
        end
    end

    // status view: ninth bit and framing flag of the oldest character, and the overrun flag
    function automatic logic [7:0] rx_status_view(input logic [7:0] c,
                                                  input rx_char_t t,
                                                  input logic ov);
        logic [7:0] v;
        v = c;
        v[RCS_FRAMING_ERROR] = t.framing;
        v[RCS_OVERRUN_ERROR] = ov;
        v[RCS_RX_NINTH_BIT] = t.ninth;
        return v;
    endfunction : rx_status_view

    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = RESET_BYTE;
        unique case (s_axi_araddr)
            OFS_GLOBAL_INT_CONTROL: rd_byte = global_int_control;
            OFS_PERIPH_INT_ENABLE: rd_byte = peripheral_int_enable_one;
            OFS_PERIPH_INT_FLAGS:
                rd_byte = {2'b00, rx_char_flag, tx_buffer_empty_flag, 4'h0};
            OFS_RX_DATA: rd_byte = rx_top.data;
            OFS_RX_STATUS_CONTROL:
                rd_byte = rx_status_view(rcs, rx_top,
                                         overrun_error_flag);
            OFS_TX_STATUS_CONTROL:
                rd_byte = {txs[7:2], tsr_empty, txs[0]};
            OFS_BAUD_DIVISOR: rd_byte = 8'(baud_divisor);
            default: rd_byte = RESET_BYTE;
        endcase
    end

    assign rx_read = s_axi_arvalid && s_axi_arready
                     && (s_axi_araddr == OFS_RX_DATA);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready
                             && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= (s_axi_araddr > OFS_BAUD_DIVISOR
                                || s_axi_araddr == OFS_TX_DATA)
                    ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : sync_serial_port

/* File: sync_serial_port_checker.sv */
// assertions on the pins and register bus of the clocked serial port
`timescale 1ns/1ps
module sync_serial_port_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_active,
    input wire logic serial_clock_in,
    input wire logic serial_clock_out,
    input wire logic serial_clock_oe_n,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_n,
    input wire logic wake_request,
    input wire logic vector_request
);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    default clocking dclk @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence aw_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    // slave transmit with the external clock high: data must hold
    sequence link_high_held;
        (serial_clock_oe_n && !serial_data_oe_n && serial_clock_in) [*5];
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_R_ANSWER: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read answer not one cycle after address");
    AST_B_ANSWER: assert property (aw_taken |-> ##[1:4] s_axi_bvalid)
        else $error("write response missing");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    AST_VECTOR_WAKE: assert property (vector_request |-> wake_request)
        else $error("vector without wake");
    AST_SLEEP_MASTER: assert property (
        (sleep_active && !serial_clock_oe_n) [*3] |-> $stable(serial_clock_out))
        else $error("master clock runs in sleep");
    AST_LINK_DATA_STABLE: assert property (
        link_high_held |=> $stable(serial_data_out))
        else $error("slave data moved while clock high");
    AST_CLK_NOT_DRIVEN: assert property (
        $changed(serial_clock_out) && serial_clock_oe_n |-> serial_clock_out)
        else $error("clock toggles while not driven");
endmodule : sync_serial_port_checker

bind sync_serial_port sync_serial_port_checker i_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sleep_active(sleep_active),
    .serial_clock_in(serial_clock_in), .serial_clock_out(serial_clock_out),
    .serial_clock_oe_n(serial_clock_oe_n), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .wake_request(wake_request),
    .vector_request(vector_request));

/* File: sync_serial_port_tb_top.sv */
// self-checking bench for the clocked serial port
`timescale 1ns/1ps
module sync_serial_port_tb_top
    import sync_serial_pkg::*;
;
    logic aclk, aresetn, sleep_active, last_clk;
    logic [4:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic clk_out, clk_oe_n, data_out, data_oe_n, wake, vector;
    logic p_clk, p_data;
    logic [8:0] q;
    wire clk_line;
    wire data_line;
    int fails, compares, cyc, edges, e0;
    assign clk_line = !clk_oe_n ? clk_out : p_clk;
    assign data_line = !data_oe_n ? data_out : p_data;
    sync_serial_port i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sleep_active(sleep_active),
        .serial_clock_in(clk_line), .serial_clock_out(clk_out),
        .serial_clock_oe_n(clk_oe_n), .serial_data_in(data_line),
        .serial_data_out(data_out), .serial_data_oe_n(data_oe_n),
        .wake_request(wake), .vector_request(vector));
    sync_serial_partner i_partner (.link_clk(p_clk), .link_data(p_data),
        .line_data(data_line));
    // ------------------------------------------------------------
    // bus tasks and checks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        logic aw_left;
        logic w_left;
        aw_left = 1'b1;
        w_left = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_left || w_left) begin
            @(posedge aclk);
            if (aw_left && awready) begin
                aw_left = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_left && wready) begin
                w_left = 1'b0;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge aclk);
        chk("write response", 32'(RESP_OKAY), 32'(bresp));
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [4:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        rd(a);
        chk("read data", {24'h000000, e}, d);
        chk("read response", 32'(RESP_OKAY), 32'(r));
    endtask : rchk
    // ------------------------------------------------------------
    // clock, timeout and master clock edge count
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        last_clk <= clk_out;
        if (last_clk && !clk_out) edges <= edges + 1;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {aresetn, sleep_active, awvalid, wvalid, bready} = 5'h00;
        {arvalid, rready, awaddr, araddr, wdata} = 44'h0;
        {fails, compares, cyc, edges, last_clk} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(OFS_TX_STATUS_CONTROL, RESET_TX_STATUS);
        rchk(OFS_RX_STATUS_CONTROL, RESET_BYTE);
        rd(OFS_TX_DATA);
        chk("write-only read response", 32'(RESP_SLVERR), 32'(r));
        wr(OFS_TX_STATUS_CONTROL, 8'h10);
        wr(OFS_RX_STATUS_CONTROL, 8'h90);
        chk("slave clock enable", 32'h1, 32'(clk_oe_n));
        i_partner.xfer(9'h05A, 8, q);
        i_partner.xfer(9'h0C3, 8, q);
        i_partner.xfer(9'h077, 8, q);
        repeat (8) @(posedge aclk);
        rchk(OFS_RX_STATUS_CONTROL, 8'h92);
        rchk(OFS_RX_DATA, 8'h5A);
        rchk(OFS_RX_DATA, 8'hC3);
        wr(OFS_RX_STATUS_CONTROL, 8'h80);
        rchk(OFS_RX_STATUS_CONTROL, 8'h80);
        wr(OFS_PERIPH_INT_ENABLE, 8'h20);
        wr(OFS_GLOBAL_INT_CONTROL, 8'h40);
        wr(OFS_RX_STATUS_CONTROL, 8'hD0);
        sleep_active <= 1'b1;
        i_partner.xfer(9'h1A5, 9, q);
        repeat (8) @(posedge aclk);
        chk("wake", 32'h1, 32'(wake));
        chk("vector", 32'h0, 32'(vector));
        wr(OFS_GLOBAL_INT_CONTROL, 8'hC0);
        @(posedge aclk);
        chk("vector", 32'h1, 32'(vector));
        sleep_active <= 1'b0;
        rchk(OFS_PERIPH_INT_FLAGS, 8'h30);
        rchk(OFS_RX_STATUS_CONTROL, 8'hD1);
        rchk(OFS_RX_DATA, 8'hA5);
        wr(OFS_RX_STATUS_CONTROL, 8'h80);
        wr(OFS_PERIPH_INT_ENABLE, 8'h10);
        wr(OFS_GLOBAL_INT_CONTROL, 8'h40);
        chk("data enable", 32'h1, 32'(data_oe_n));
        wr(OFS_TX_STATUS_CONTROL, 8'h30);
        chk("data enable", 32'h0, 32'(data_oe_n));
        wr(OFS_TX_DATA, 8'h3C);
        wr(OFS_TX_DATA, 8'h81);
        sleep_active <= 1'b1;
        rchk(OFS_PERIPH_INT_FLAGS, 8'h00);
        i_partner.xfer(9'h000, 8, q);
        chk("sent char", 32'h3C, 32'(q));
        repeat (8) @(posedge aclk);
        chk("wake", 32'h1, 32'(wake));
        chk("vector", 32'h0, 32'(vector));
        rchk(OFS_PERIPH_INT_FLAGS, 8'h10);
        i_partner.xfer(9'h000, 8, q);
        chk("sent char", 32'h81, 32'(q));
        sleep_active <= 1'b0;
        wr(OFS_TX_STATUS_CONTROL, 8'h71);
        wr(OFS_TX_DATA, 8'hE4);
        i_partner.xfer(9'h000, 9, q);
        chk("sent char", 32'h1E4, 32'(q));
        wr(OFS_BAUD_DIVISOR, 8'h01);
        wr(OFS_TX_STATUS_CONTROL, 8'h90);
        chk("master clock enable", 32'h0, 32'(clk_oe_n));
        e0 = edges;
        wr(OFS_RX_STATUS_CONTROL, 8'hA0);
        chk("data enable", 32'h1, 32'(data_oe_n));
        repeat (80) @(posedge aclk);
        chk("master clock count", 32'h8, 32'(edges - e0));
        rchk(OFS_RX_STATUS_CONTROL, 8'h80);
        rchk(OFS_RX_DATA, 8'hFF);
        sleep_active <= 1'b1;
        repeat (6) @(posedge aclk);
        sleep_active <= 1'b0;
        report_and_stop();
    end
endmodule : sync_serial_port_tb_top
